//--- hdl/gpio_port_params.svh
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PORT_W 8
`define ADDR_W 8
`define STEER_W 2

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_LEVEL 8'h00
`define ADDR_DIR 8'h01
`define ADDR_LATCH 8'h02
`define ADDR_ANALOG 8'h03
`define ADDR_STEER 8'h04
`define ADDR_LEVEL_SET 8'h05
`define ADDR_LEVEL_CLR 8'h06

// ----------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------
`define DIR_RST 8'hff
`define LATCH_RST 8'h00
`define ANALOG_MASK 8'h2f
`define ANALOG_RST 8'h2f
`define STEER_RST 2'h0
`define STEER_SS_BIT 1
`define STEER_CAP_BIT 0
`define SS_PIN_DEFAULT 5
`define SS_PIN_ALT 0
`define ZERO_BYTE 8'h00

`endif

//--- hdl/gpio_port_pkg.sv
package gpio_port_pkg;

`include "gpio_port_params.svh"

    typedef logic [`PORT_W-1:0] byte_t;

    // Register port request
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        byte_t wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // Override that the steering logic hands to a pin of another port
    typedef struct packed {
        logic en;
        logic out;
        logic oe;
    } pin_ovr_t;

    // Whole state of the port
    typedef struct packed {
        byte_t dir;
        byte_t latch;
        byte_t analog;
        logic [`STEER_W-1:0] steer;
        byte_t sync1;
        byte_t sync2;
        byte_t rdata;
        byte_t pinOut;
        byte_t pinOe;
        pin_ovr_t ovrC1;
        pin_ovr_t ovrB3;
        logic ssIn;
        logic capIn;
    } port_state_t;

endpackage

//--- hdl/gpio_port_with_pin_steering.sv
// What this block does
// RULE1: Eight-bit bidirectional port, each pin separately input or output.
// RULE2: Direction bit 1 turns driver off; 0 drives the output latch value.
// RULE3: Port read returns pin levels; port write stores into the output latch.
// RULE4: Latch write equals port write; latch read returns latch contents.
// RULE5: Port bit set/clear writes are read-modify-write: pins read, bits modified, latch stored.
// RULE6: Direction bits control drivers even on analog pins; software keeps them set.
// RULE7: Analog-selected pins read zero on every digital port read.
// RULE8: Analog select disables the pin's digital input buffer.
// RULE9: Analog select never affects digital output drive.
// RULE10: Software expects read-modify-write to corrupt analog pins driven as outputs.
// RULE11: Analog select bits reset to analog; software clears them for digital use.
// RULE12: Enabled peripheral takes over pin output; pin stays readable.
// RULE13: Steering bit 1 puts slave select on port A bit 5 or bit 0.
// RULE14: Steering bit 0 puts capture unit 2 on port C bit 1 or B bit 3.
// RULE15: Steering never alters direction bits; overrides follow selected pin only.
// RULE16: Direction bits reset to one, all pins start as inputs.
// RULE17: Only analog bits 5 and 3..0 exist, resetting to one; others read zero.
// RULE18: Pin levels pass a two-stage synchroniser before the read path.
`timescale 1ns/1ps

`include "gpio_port_params.svh"

module gpio_port_with_pin_steering (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire gpio_port_pkg::bus_req_t busReq,
    output gpio_port_pkg::byte_t busRdata,
    // Port A pins
    input wire gpio_port_pkg::byte_t pinIn,
    output gpio_port_pkg::byte_t pinOut,
    output gpio_port_pkg::byte_t pinOe,
    // Peripheral overrides on port A
    input wire gpio_port_pkg::byte_t periphEn,
    input wire gpio_port_pkg::byte_t periphOut,
    input wire gpio_port_pkg::byte_t periphOe,
    // Slave select routed to the serial unit
    output logic slaveSelectIn,
    // Capture unit 2 and its two candidate pins
    input wire logic capEn,
    input wire logic capOut,
    input wire logic capOe,
    output logic capIn,
    input wire logic portCBit1Level,
    input wire logic portBBit3Level,
    output gpio_port_pkg::pin_ovr_t portCBit1Ovr,
    output gpio_port_pkg::pin_ovr_t portBBit3Ovr,
    // Analog select bits for the converter
    output gpio_port_pkg::byte_t analogSelect
);
    import gpio_port_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic byte_t digRead(input byte_t lvl, input byte_t ana);
        digRead = lvl & ~ana;
    endfunction

    function automatic byte_t pick(input byte_t sel, input byte_t a, input byte_t b);
        pick = (sel & a) | (~sel & b);
    endfunction

    port_state_t st_ff;
    port_state_t nxt_st;
    byte_t pinView;
    byte_t gatedIn;

    // Analog pins read zero everywhere, including inside read-modify-write
    assign pinView = digRead(st_ff.sync2, st_ff.analog); // [RULE7]
    // Buffer disabled ahead of the synchroniser so analog levels never toggle it
    assign gatedIn = digRead(pinIn, st_ff.analog); // [RULE8]

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync1 = gatedIn; // [RULE18]
        nxt_st.sync2 = st_ff.sync1; // [RULE18]
        nxt_st.rdata = `ZERO_BYTE;

        if (busReq.wr) begin
            unique case (busReq.addr)
                `ADDR_LEVEL,
                `ADDR_LATCH: begin
                    nxt_st.latch = busReq.wdata; // [RULE3] [RULE4]
                end
                `ADDR_LEVEL_SET: begin
                    // Modifies what the pins read, not the latch [RULE5] [RULE10]
                    nxt_st.latch = pinView | busReq.wdata;
                end
                `ADDR_LEVEL_CLR: begin
                    nxt_st.latch = pinView & ~busReq.wdata; // [RULE5] [RULE10]
                end
                `ADDR_DIR: begin
                    nxt_st.dir = busReq.wdata; // [RULE1]
                end
                `ADDR_ANALOG: begin
                    nxt_st.analog = busReq.wdata & `ANALOG_MASK; // [RULE17]
                end
                `ADDR_STEER: begin
                    // Touches only the steering bits, never direction [RULE15]
                    nxt_st.steer = busReq.wdata[`STEER_W-1:0];
                end
                default: begin
                end
            endcase
        end

        if (busReq.rd) begin
            unique case (busReq.addr)
                `ADDR_LEVEL: nxt_st.rdata = pinView; // [RULE3]
                `ADDR_LATCH: nxt_st.rdata = st_ff.latch; // [RULE4]
                `ADDR_DIR: nxt_st.rdata = st_ff.dir;
                `ADDR_ANALOG: nxt_st.rdata = st_ff.analog; // [RULE17]
                `ADDR_STEER: nxt_st.rdata = {{(`PORT_W-`STEER_W){1'b0}}, st_ff.steer};
                default: nxt_st.rdata = `ZERO_BYTE;
            endcase
        end

        // Driver: peripheral wins, else latch under the direction bit; analog ignored
        nxt_st.pinOut = pick(periphEn, periphOut, st_ff.latch); // [RULE12] [RULE9]
        nxt_st.pinOe = pick(periphEn, periphOe, ~st_ff.dir); // [RULE2] [RULE6] [RULE9]

        // Slave select input follows the chosen pin
        nxt_st.ssIn = st_ff.steer[`STEER_SS_BIT] ? pinView[`SS_PIN_ALT]
                                                 : pinView[`SS_PIN_DEFAULT]; // [RULE13]

        // Capture unit 2 override goes to the selected pin only
        nxt_st.ovrC1.en = capEn & ~st_ff.steer[`STEER_CAP_BIT]; // [RULE14] [RULE15]
        nxt_st.ovrC1.out = capOut;
        nxt_st.ovrC1.oe = capOe;
        nxt_st.ovrB3.en = capEn & st_ff.steer[`STEER_CAP_BIT]; // [RULE14] [RULE15]
        nxt_st.ovrB3.out = capOut;
        nxt_st.ovrB3.oe = capOe;
        nxt_st.capIn = st_ff.steer[`STEER_CAP_BIT] ? portBBit3Level : portCBit1Level; // [RULE14]
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_ff <= '0;
            st_ff.dir <= `DIR_RST; // [RULE16]
            st_ff.latch <= `LATCH_RST;
            st_ff.analog <= `ANALOG_RST; // [RULE11] [RULE17]
            st_ff.steer <= `STEER_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busRdata = st_ff.rdata;
    assign pinOut = st_ff.pinOut;
    assign pinOe = st_ff.pinOe;
    assign slaveSelectIn = st_ff.ssIn;
    assign capIn = st_ff.capIn;
    assign portCBit1Ovr = st_ff.ovrC1;
    assign portBBit3Ovr = st_ff.ovrB3;
    assign analogSelect = st_ff.analog;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_dir_reset: assert property (@(posedge mclk) // [RULE16]
        !resetn |=> st_ff.dir == `DIR_RST)
        else $error("direction bits not all inputs after reset");

    a_analog_reset: assert property (@(posedge mclk) // [RULE11]
        !resetn |=> st_ff.analog == `ANALOG_RST)
        else $error("analog select not set after reset");

    a_latch_reset: assert property (@(posedge mclk) // [RULE4]
        !resetn |=> st_ff.latch == `LATCH_RST)
        else $error("output latch not cleared by reset");

    a_steer_reset: assert property (@(posedge mclk) // [RULE13] [RULE14]
        !resetn |=> st_ff.steer == `STEER_RST)
        else $error("steering bits not cleared by reset");

    a_analog_mask: assert property (@(posedge mclk) disable iff (!resetn) // [RULE17]
        (st_ff.analog & ~`ANALOG_MASK) == `ZERO_BYTE)
        else $error("unimplemented analog bit set");

    a_level_read: assert property (@(posedge mclk) disable iff (!resetn) // [RULE3]
        busReq.rd && busReq.addr == `ADDR_LEVEL |=> busRdata == $past(pinView))
        else $error("port read does not show pin view");

    a_analog_zero: assert property (@(posedge mclk) disable iff (!resetn) // [RULE7]
        busReq.rd && busReq.addr == `ADDR_LEVEL |=>
        (busRdata & $past(st_ff.analog)) == `ZERO_BYTE)
        else $error("analog pin read non-zero");

    a_latch_read: assert property (@(posedge mclk) disable iff (!resetn) // [RULE4]
        busReq.rd && busReq.addr == `ADDR_LATCH |=> busRdata == $past(st_ff.latch))
        else $error("latch read does not show latch");

    a_dir_read: assert property (@(posedge mclk) disable iff (!resetn) // [RULE2]
        busReq.rd && busReq.addr == `ADDR_DIR |=> busRdata == $past(st_ff.dir))
        else $error("direction read mismatch");

    a_analog_read: assert property (@(posedge mclk) disable iff (!resetn) // [RULE17]
        busReq.rd && busReq.addr == `ADDR_ANALOG |=> busRdata == $past(st_ff.analog))
        else $error("analog select read mismatch");

    a_steer_read: assert property (@(posedge mclk) disable iff (!resetn) // [RULE13] [RULE14]
        busReq.rd && busReq.addr == `ADDR_STEER |=>
        busRdata == {{(`PORT_W-`STEER_W){1'b0}}, $past(st_ff.steer)})
        else $error("steering read mismatch");

    a_unmapped_read: assert property (@(posedge mclk) disable iff (!resetn) // [RULE3]
        busReq.rd && busReq.addr > `ADDR_LEVEL_CLR |=> busRdata == `ZERO_BYTE)
        else $error("unmapped read not zero");

    a_idle_rdata: assert property (@(posedge mclk) disable iff (!resetn) // [RULE3]
        !$past(busReq.rd) |-> busRdata == `ZERO_BYTE)
        else $error("read data stands outside its cycle");

    a_write_latch: assert property (@(posedge mclk) disable iff (!resetn) // [RULE3]
        busReq.wr && (busReq.addr == `ADDR_LEVEL || busReq.addr == `ADDR_LATCH)
        |=> st_ff.latch == $past(busReq.wdata) ##1 pinOut == pick($past(periphEn),
        $past(periphOut), $past(st_ff.latch)))
        else $error("port write did not reach latch and pin");

    a_rmw_set: assert property (@(posedge mclk) disable iff (!resetn) // [RULE5]
        busReq.wr && busReq.addr == `ADDR_LEVEL_SET
        |=> st_ff.latch == ($past(pinView) | $past(busReq.wdata)))
        else $error("bit set not based on pin view");

    a_rmw_clear: assert property (@(posedge mclk) disable iff (!resetn) // [RULE5]
        busReq.wr && busReq.addr == `ADDR_LEVEL_CLR
        |=> st_ff.latch == ($past(pinView) & ~$past(busReq.wdata)))
        else $error("bit clear not based on pin view");

    a_dir_write: assert property (@(posedge mclk) disable iff (!resetn) // [RULE1]
        busReq.wr && busReq.addr == `ADDR_DIR |=> st_ff.dir == $past(busReq.wdata))
        else $error("direction write lost");

    a_dir_hold: assert property (@(posedge mclk) disable iff (!resetn) // [RULE15]
        !(busReq.wr && busReq.addr == `ADDR_DIR) |=> $stable(st_ff.dir))
        else $error("direction changed without a direction write");

    a_analog_write: assert property (@(posedge mclk) disable iff (!resetn) // [RULE17]
        busReq.wr && busReq.addr == `ADDR_ANALOG
        |=> st_ff.analog == ($past(busReq.wdata) & `ANALOG_MASK))
        else $error("analog select write mismatch");

    a_steer_write: assert property (@(posedge mclk) disable iff (!resetn) // [RULE13] [RULE14]
        busReq.wr && busReq.addr == `ADDR_STEER
        |=> st_ff.steer == $past(busReq.wdata[`STEER_W-1:0]))
        else $error("steering write mismatch");

    a_drive_enable: assert property (@(posedge mclk) disable iff (!resetn) // [RULE2]
        ##1 pinOe == pick($past(periphEn), $past(periphOe), ~$past(st_ff.dir)))
        else $error("driver enable mismatch");

    a_pin_drive: assert property (@(posedge mclk) disable iff (!resetn) // [RULE9] [RULE12]
        $past(resetn) |->
        pinOut == pick($past(periphEn), $past(periphOut), $past(st_ff.latch)))
        else $error("driven pin value mismatch");

    a_input_gate: assert property (@(posedge mclk) disable iff (!resetn) // [RULE8]
        $past(resetn) |-> (st_ff.sync1 & $past(st_ff.analog)) == `ZERO_BYTE)
        else $error("analog pin reached the synchroniser");

    a_ss_steer: assert property (@(posedge mclk) disable iff (!resetn) // [RULE13]
        ##1 slaveSelectIn == ($past(st_ff.steer[`STEER_SS_BIT]) ?
        $past(pinView[`SS_PIN_ALT]) : $past(pinView[`SS_PIN_DEFAULT])))
        else $error("slave select on wrong pin");

    a_ss_analog: assert property (@(posedge mclk) disable iff (!resetn) // [RULE7]
        $past(resetn) && $past(st_ff.analog[`SS_PIN_DEFAULT]) &&
        !$past(st_ff.steer[`STEER_SS_BIT]) |-> !slaveSelectIn)
        else $error("slave select sees an analog pin");

    a_cap_steer: assert property (@(posedge mclk) disable iff (!resetn) // [RULE14]
        ##1 !(portCBit1Ovr.en && portBBit3Ovr.en) &&
        (portCBit1Ovr.en | portBBit3Ovr.en) == $past(capEn))
        else $error("capture override on both or wrong pins");

    a_cap_route: assert property (@(posedge mclk) disable iff (!resetn) // [RULE14] [RULE15]
        $past(resetn) |->
        portBBit3Ovr.en == ($past(capEn) && $past(st_ff.steer[`STEER_CAP_BIT])))
        else $error("capture override on unselected pin");

    a_cap_input: assert property (@(posedge mclk) disable iff (!resetn) // [RULE14]
        $past(resetn) |-> capIn == ($past(st_ff.steer[`STEER_CAP_BIT]) ?
        $past(portBBit3Level) : $past(portCBit1Level)))
        else $error("capture input from wrong pin");

    a_ovr_pass: assert property (@(posedge mclk) disable iff (!resetn) // [RULE15]
        $past(resetn) |->
        portCBit1Ovr.out == $past(capOut) && portCBit1Ovr.oe == $past(capOe) &&
        portBBit3Ovr.out == $past(capOut) && portBBit3Ovr.oe == $past(capOe))
        else $error("capture override value or enable lost");

    a_steer_keeps_dir: assert property (@(posedge mclk) disable iff (!resetn) // [RULE15]
        busReq.wr && busReq.addr == `ADDR_STEER |=> $stable(st_ff.dir))
        else $error("steering write changed direction");

    a_sync_depth: assert property (@(posedge mclk) disable iff (!resetn) // [RULE18]
        $past(resetn, 2) && $stable(st_ff.analog) && $past(st_ff.analog, 2) == st_ff.analog
        |-> st_ff.sync2 == $past(gatedIn, 2))
        else $error("synchroniser depth not two");

    c_rmw_clear: cover property (@(posedge mclk) disable iff (!resetn)
        busReq.wr && busReq.addr == `ADDR_LEVEL_CLR);
    c_analog_output: cover property (@(posedge mclk) disable iff (!resetn)
        (st_ff.analog & ~st_ff.dir) != `ZERO_BYTE);
    c_cap_alt: cover property (@(posedge mclk) disable iff (!resetn)
        portBBit3Ovr.en);
    c_ss_alt: cover property (@(posedge mclk) disable iff (!resetn)
        st_ff.steer[`STEER_SS_BIT] && busReq.rd);
    c_periph_take: cover property (@(posedge mclk) disable iff (!resetn)
        periphEn != `ZERO_BYTE);

endmodule

//--- tb/gpio_pad_model.sv
`timescale 1ns/1ps

module gpio_pad_model (
    // Clock
    input wire logic mclk,
    // Port side
    input wire gpio_port_pkg::byte_t pinOut,
    input wire gpio_port_pkg::byte_t pinOe,
    // Far side drive
    input wire gpio_port_pkg::byte_t extDrv,
    input wire gpio_port_pkg::byte_t extOe,
    output gpio_port_pkg::byte_t pinIn
);
    import gpio_port_pkg::*;
    byte_t floatLvl;
    // A floating pin flips every cycle so a stale level is never mistaken for a real one
    initial floatLvl = 8'h5a;
    always @(posedge mclk) floatLvl <= ~floatLvl;
    assign pinIn = (pinOut & pinOe) | (extDrv & extOe & ~pinOe) | (floatLvl & ~pinOe & ~extOe);
endmodule

//--- tb/gpio_port_with_pin_steering_tb_top.sv
`timescale 1ns/1ps

module gpio_port_with_pin_steering_tb_top;
    import gpio_port_pkg::*;
    logic mclk;
    logic resetn;
    logic rdPend;
    logic slaveSelectIn, capEn, capOut, capOe, capIn, cLvl, bLvl;
    logic [1:0] s;
    bus_req_t busReq;
    byte_t busRdata, pinIn, pinOut, pinOe, periphEn, periphOut, periphOe;
    byte_t anaSel, extDrv, extOe, lf, r, e, d, po;
    pin_ovr_t cOvr, bOvr;
    byte_t expQ[$];
    int n_fail, n_tests;

    gpio_port_with_pin_steering gpio_port_with_pin_steering_i (
        .mclk(mclk), .resetn(resetn), .busReq(busReq), .busRdata(busRdata),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .periphEn(periphEn),
        .periphOut(periphOut), .periphOe(periphOe), .slaveSelectIn(slaveSelectIn),
        .capEn(capEn), .capOut(capOut), .capOe(capOe), .capIn(capIn),
        .portCBit1Level(cLvl), .portBBit3Level(bLvl), .portCBit1Ovr(cOvr),
        .portBBit3Ovr(bOvr), .analogSelect(anaSel));
    gpio_pad_model gpio_pad_model_i (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe),
        .extDrv(extDrv), .extOe(extOe), .pinIn(pinIn));

    // --------------------------------
    // Helpers
    // --------------------------------
    function automatic byte_t lfsr(byte_t v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic cmp(byte_t got, byte_t exp, string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(byte_t a, byte_t v);
        busReq <= '{a, v, 1'b1, 1'b0};
        @(posedge mclk);
        busReq <= '0;
        @(posedge mclk);
    endtask
    task automatic rd(byte_t a, byte_t x);
        expQ.push_back(x);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        busReq <= '0;
        @(posedge mclk);
    endtask
    task automatic settle;
        repeat (6) @(posedge mclk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // --------------------------------
    // Clock, monitor, watchdog
    // --------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) rdPend <= busReq.rd;
    always @(negedge mclk) begin
        if (rdPend === 1'b1) begin
            cmp(busRdata, expQ.pop_front(), "read");
        end else if (resetn === 1'b1) begin
            cmp(busRdata, 8'h00, "idle rdata");
        end
    end
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        tally_and_finish();
    end

    // --------------------------------
    // Scenarios
    // --------------------------------
    initial begin
        resetn = 1'b0; busReq = '0; periphEn = '0; periphOut = '0; periphOe = '0;
        capEn = 1'b0; capOut = 1'b0; capOe = 1'b0; cLvl = 1'b0; bLvl = 1'b0;
        extDrv = '0; extOe = '0; lf = 8'h1d; n_fail = 0; n_tests = 0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        lf = lfsr(lf);
        e = lf;
        extDrv <= e;
        extOe <= 8'hff;
        cmp(pinOe, 8'h00, "oe at reset");
        rd(8'h01, 8'hff);
        rd(8'h03, 8'h2f);
        rd(8'h04, 8'h00);
        rd(8'h07, 8'h00);
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h2f);
        rd(8'h00, e & 8'hd0);
        cmp(anaSel, 8'h2f, "analog out");
        wr(8'h03, 8'h00);
        settle();
        rd(8'h00, e);
        lf = lfsr(lf);
        extDrv <= lf;
        rd(8'h00, e);
        e = lf;
        settle();
        rd(8'h00, e);
        // Mixed directions: driven bits show the latch, the rest the far side
        lf = lfsr(lf);
        r = lf;
        lf = lfsr(lf);
        d = lf;
        wr(8'h02, r);
        wr(8'h01, d);
        settle();
        cmp(pinOe, ~d, "oe mixed");
        cmp(pinOut & ~d, r & ~d, "out mixed");
        rd(8'h02, r);
        rd(8'h00, (r & ~d) | (e & d));
        wr(8'h00, 8'h3c);
        rd(8'h02, 8'h3c);
        wr(8'h01, 8'h00);
        settle();
        wr(8'h05, 8'h81);
        rd(8'h02, 8'hbd);
        wr(8'h06, 8'h0c);
        rd(8'h02, 8'hb1);
        // Output pin selected analog still drives, and reads back low on modify
        wr(8'h02, 8'hff);
        wr(8'h03, 8'h01);
        settle();
        cmp(pinOe, 8'hff, "oe analog");
        cmp(pinOut, 8'hff, "out analog");
        wr(8'h05, 8'h00);
        rd(8'h02, 8'hfe);
        wr(8'h03, 8'h00);
        periphEn <= 8'h81;
        periphOut <= 8'h01;
        periphOe <= 8'h80;
        settle();
        po = 8'h7f;
        cmp(pinOe, 8'hfe, "oe periph");
        cmp(pinOut & 8'hfe, po & 8'hfe, "out periph");
        rd(8'h00, (po & 8'hfe) | (e & 8'h01));
        periphEn <= 8'h00;
        wr(8'h01, 8'hff);
        extDrv <= 8'h20;
        cLvl <= 1'b1;
        capEn <= 1'b1;
        capOut <= 1'b1;
        capOe <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            s = i[1:0];
            wr(8'h04, {6'h00, s});
            settle();
            cmp(byte_t'(slaveSelectIn), {7'h00, ~s[1]}, "slave select");
            cmp(byte_t'(capIn), {7'h00, ~s[0]}, "capture in");
            cmp(byte_t'(cOvr), byte_t'({~s[0], 2'b11}), "ovr c1");
            cmp(byte_t'(bOvr), byte_t'({s[0], 2'b11}), "ovr b3");
            rd(8'h04, {6'h00, s});
            rd(8'h01, 8'hff);
        end
        // Second reset in mid-run; capture request dropped so no stale override follows
        capEn <= 1'b0;
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rd(8'h04, 8'h00);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h2f);
        rd(8'h01, 8'hff);
        settle();
        tally_and_finish();
    end
endmodule
